// ===== rtl/srs_consts.vh
// constants for the supply and regulator supervisor
// assumes a 100 MHz pclk and a 32-bit APB slave
`ifndef SRS_CONSTS_VH
`define SRS_CONSTS_VH
// register byte addresses
`define SRS_ADDR_STATUS   12'h000
`define SRS_ADDR_CLEAR    12'h004
`define SRS_ADDR_CTRL     12'h008
`define SRS_ADDR_LIVE     12'h00C
// status bit positions
`define SRS_ST_COLD       0
`define SRS_ST_SUP_LOW    1
`define SRS_ST_SUP_HIGH   2
`define SRS_ST_MAIN_FAIL  3
`define SRS_ST_AUX_FAIL   4
`define SRS_ST_AUX_SHORT  5
`define SRS_ST_THERM1     6
`define SRS_ST_THERM2     7
`define SRS_ST_WIDTH      8
// control bit positions
`define SRS_CT_UV_DRV_OFF 0
`define SRS_CT_OV_DRV_OFF 1
`define SRS_CT_AUX_EN     2
`define SRS_CT_RES_LSB    3
`define SRS_CT_RES_MSB    4
`define SRS_CT_STANDBY    5
`define SRS_CT_WIDTH      6
`define SRS_CT_RESET      6'h03
// timing counts in pclk cycles at 100 MHz, sized to the 27-bit counters:
// 5 us main dip, 16 us reset filter, 2 us aux dip, 4 ms short, 1 s off
`define SRS_MAIN_DIP_CYC  27'h00001F4
`define SRS_MAIN_RES_CYC  27'h0000640
`define SRS_AUX_DIP_CYC   27'h00000C8
`define SRS_SHORT_CYC     27'h0061A80
`define SRS_THERM_OFF_CYC 27'h5F5E100
`define SRS_THERM_REPEAT  3'h3
`define SRS_CNT_W         27
`endif

// ===== rtl/srs_filter.v
// low-level duration filter: counts cycles a condition holds
// assumes a synchronous input in the pclk domain
`timescale 1ns/1ns
`default_nettype none
module srs_filter #(
    parameter [26:0] LIMIT = 27'h1
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clr,
    input  wire        cond,
    output reg         hit
);
    reg [26:0] count;

    // count while cond holds; hit once cond has held for LIMIT cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 27'h0;
            hit   <= 1'b0;
        end else if (clr || !cond) begin
            count <= 27'h0;
            hit   <= 1'b0;
        end else if (count >= LIMIT - 27'h1) begin
            hit <= 1'b1;
        end else begin
            count <= count + 27'h1;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/srs_supervisor.v
// supply and regulator supervisor with APB register access
// assumes comparator inputs come from the analog domain (synchronised)
`timescale 1ns/1ns
`default_nettype none
`include "srs_consts.vh"
// Overview of operation
// RL1 - below power-on threshold stay passive, registers at defaults
// RL2 - on power-on enter power-up and latch power-on event flag
// RL3 - supply low: block LIN send, drivers off per config, set flag
// RL4 - supply high: drivers off per config, set flag
// RL5 - second thermal level: main regulator off about one second
// RL6 - repeated second-level thermal shutdowns force sleep
// RL7 - main regulator not up within 4 ms at start: sleep
// RL8 - main regulator dip over 5 us counts as failure
// RL9 - both main failures latch one main failure flag
// RL10 - reset threshold selectable among four settings
// RL11 - main below reset threshold over 16 us asserts reset low
// RL12 - after reset, loads and aux off until release and watchdog served
// RL13 - standby disables watchdog only under low consumption
// RL14 - standby re-enables watchdog on rising consumption
// RL15 - first thermal level: all drivers and aux off, flag set
// RL16 - aux compared only while its regulator is enabled, which is in normal mode
// RL17 - aux dip over 2 us latches transient failure, stays on
// RL18 - aux low 4 ms is short: disable, set failure and short
// RL19 - both aux flags read-cleared before re-enable; control kept
// RL20 - flags stay latched until software read-clear
module srs_supervisor #(
    parameter [26:0] SHORT_CYC = `SRS_SHORT_CYC,
    parameter [26:0] THERM_CYC = `SRS_THERM_OFF_CYC
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        supply_above_por,
    input  wire        supply_low,
    input  wire        supply_high,
    input  wire        main_above_fail,
    input  wire [3:0]  main_below_res,
    input  wire        aux_above_fail,
    input  wire        therm_level1,
    input  wire        therm_level2,
    input  wire        load_current_low,
    input  wire        load_current_high,
    input  wire        wdog_served,
    input  wire        cyclic_sense,
    input  wire        mcu_reset_in,
    output reg         mcu_reset_out_n_o,
    output wire        mcu_reset_out_n_oe_n,
    output reg         main_regulator_en,
    output reg         aux_regulator_en,
    output reg         drivers_en,
    output reg         lin_tx_en,
    output reg         wdog_en,
    output reg         force_sleep
);
    localparam [3:0] ST_OFF   = 4'h1;
    localparam [3:0] ST_START = 4'h2;
    localparam [3:0] ST_RUN   = 4'h4;
    localparam [3:0] ST_SLEEP = 4'h8;

    // two-flop synchronisers for all analog comparator pins
    // nothing but sync2 reads sync1; every pin here is an async level
    localparam NSYNC = 16;
    wire [NSYNC-1:0] raw_in = {mcu_reset_in, cyclic_sense, wdog_served,
        load_current_high, load_current_low, therm_level2, therm_level1,
        aux_above_fail, main_below_res, main_above_fail, supply_high,
        supply_low, supply_above_por};
    reg  [NSYNC-1:0] sync1;
    reg  [NSYNC-1:0] sync2;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= {NSYNC{1'b0}};
            sync2 <= {NSYNC{1'b0}};
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
        end
    end
    wire por_ok   = sync2[0];
    wire sup_low  = sync2[1];
    wire sup_high = sync2[2];
    wire main_up  = sync2[3];
    wire [3:0] res_low = sync2[7:4];
    wire aux_up   = sync2[8];
    wire th1      = sync2[9];
    wire th2      = sync2[10];
    wire cur_low  = sync2[11];
    wire cur_high = sync2[12];
    wire wd_ok    = sync2[13];
    wire cyc_sns  = sync2[14];
    wire line_hi  = sync2[15]; // reset line read back from the pin

    // registers and state
    reg [`SRS_ST_WIDTH-1:0] status;
    reg [`SRS_CT_WIDTH-1:0] ctrl;
    reg [3:0]               state;
    reg [3:0]               next_state;
    reg                     reset_hold;
    reg                     th2_prev;
    reg [2:0]               th2_count;
    reg [26:0]              th_timer;
    reg                     th_off;
    reg                     aux_block;

    // APB decode: zero-wait answers, error on unmapped address
    wire acc     = psel && penable;
    wire wr      = acc && pwrite;
    wire rd      = acc && !pwrite;
    wire mapped  = (paddr == `SRS_ADDR_STATUS) || (paddr == `SRS_ADDR_CLEAR)
                   || (paddr == `SRS_ADDR_CTRL) || (paddr == `SRS_ADDR_LIVE);
    wire rd_clr  = rd && (paddr == `SRS_ADDR_CLEAR);
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;
    // open drain: pin driven low only while reset is asserted
    assign mcu_reset_out_n_oe_n = mcu_reset_out_n_o;

    // duration filters on comparator levels
    wire running   = (state == ST_RUN);
    wire starting  = (state == ST_START);
    wire aux_watch = aux_regulator_en && (running || starting || cyc_sns);
    wire [1:0] res_sel = ctrl[`SRS_CT_RES_MSB:`SRS_CT_RES_LSB];
    wire main_dip;
    wire main_short;
    wire res_dip;
    wire aux_dip;
    wire aux_short;
    srs_filter #(.LIMIT(`SRS_MAIN_DIP_CYC)) u_main_dip (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (!running),
        .cond    (!main_up),
        .hit     (main_dip)
    ); // [RL8]
    srs_filter #(.LIMIT(SHORT_CYC)) u_main_short (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (!starting),
        .cond    (!main_up),
        .hit     (main_short)
    ); // [RL7]
    srs_filter #(.LIMIT(`SRS_MAIN_RES_CYC)) u_res (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (!running),
        .cond    (res_low[res_sel]),
        .hit     (res_dip)
    ); // [RL10] [RL11]
    srs_filter #(.LIMIT(`SRS_AUX_DIP_CYC)) u_aux_dip (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (!aux_watch),
        .cond    (!aux_up),
        .hit     (aux_dip)
    ); // [RL16] [RL17]
    srs_filter #(.LIMIT(SHORT_CYC)) u_aux_short (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (!aux_watch),
        .cond    (!aux_up),
        .hit     (aux_short)
    ); // [RL16] [RL18]

    wire th2_rise = th2 && !th2_prev;
    wire go_sleep = main_short
                    || (th2_rise && th2_count >= `SRS_THERM_REPEAT);

    // power state sequence
    always @* begin
        next_state = state;
        case (state)
            ST_OFF:   if (por_ok) next_state = ST_START; // [RL2]
            ST_START: begin
                if (main_short) next_state = ST_SLEEP; // [RL7]
                else if (main_up) next_state = ST_RUN;
            end
            ST_RUN:   if (go_sleep) next_state = ST_SLEEP; // [RL6]
            ST_SLEEP: next_state = ST_SLEEP;
            default:  next_state = ST_OFF;
        endcase
        if (!por_ok) next_state = ST_OFF; // [RL1]
    end

    // state register; leaves OFF only once the supply is above the power-on threshold
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // status flags: hardware set wins over read-clear
    wire [`SRS_ST_WIDTH-1:0] set_vec;
    assign set_vec[`SRS_ST_COLD]      = (state == ST_OFF) && por_ok; // [RL2]
    assign set_vec[`SRS_ST_SUP_LOW]   = sup_low; // [RL3]
    assign set_vec[`SRS_ST_SUP_HIGH]  = sup_high; // [RL4]
    assign set_vec[`SRS_ST_MAIN_FAIL] = main_dip || main_short; // [RL9]
    assign set_vec[`SRS_ST_AUX_FAIL]  = aux_dip || aux_short; // [RL17]
    assign set_vec[`SRS_ST_AUX_SHORT] = aux_short; // [RL18]
    assign set_vec[`SRS_ST_THERM1]    = th1; // [RL15]
    assign set_vec[`SRS_ST_THERM2]    = th2;
    // read-clear drops only the bits that the setup edge handed out
    wire [`SRS_ST_WIDTH-1:0] clr_mask = rd_clr ? prdata[`SRS_ST_WIDTH-1:0]
                                               : {`SRS_ST_WIDTH{1'b0}};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= {`SRS_ST_WIDTH{1'b0}};
        end else if (!por_ok) begin
            status <= {`SRS_ST_WIDTH{1'b0}}; // [RL1]
        end else begin
            // an event between setup and access edge stays latched
            status <= (status & ~clr_mask) | set_vec; // [RL20]
        end
    end

    // control register; never touched by hardware faults
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `SRS_CT_RESET;
        end else if (!por_ok) begin
            ctrl <= `SRS_CT_RESET; // [RL1]
        end else if (wr && paddr == `SRS_ADDR_CTRL) begin
            ctrl <= pwdata[`SRS_CT_WIDTH-1:0]; // [RL19]
        end
    end

    // aux block: set on short, lifted once both flags read clear
    // the enable bit in ctrl is left alone; only this block keeps the
    // regulator off, so software still sees its own setting afterwards
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_block <= 1'b0;
        end else if (aux_short) begin
            aux_block <= 1'b1; // [RL18]
        end else if (!status[`SRS_ST_AUX_FAIL]
                     && !status[`SRS_ST_AUX_SHORT]) begin
            aux_block <= 1'b0; // [RL19]
        end
    end

    // thermal second level: one-second off window and repeat count
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            th2_prev  <= 1'b0;
            th2_count <= 3'h0;
            th_timer  <= 27'h0;
            th_off    <= 1'b0;
        end else begin
            th2_prev <= th2;
            if (th2_rise && !th_off) begin
                th_off   <= 1'b1; // [RL5]
                th_timer <= THERM_CYC - 27'h1;
                if (th2_count != 3'h7) th2_count <= th2_count + 3'h1;
            end else if (th_off) begin
                if (th_timer == 27'h0) begin
                    th_off <= 1'b0;
                end else begin
                    th_timer <= th_timer - 27'h1;
                end
            end
            // the repeat count only forgets on a fresh power-on
            if (state == ST_OFF) begin
                th2_count <= 3'h0;
            end
        end
    end

    // reset output low outside run or on res_dip; load hold kept until line released and watchdog served
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mcu_reset_out_n_o <= 1'b0;
            reset_hold        <= 1'b1;
        end else begin
            if (!running || res_dip) begin
                mcu_reset_out_n_o <= 1'b0; // [RL11]
                reset_hold        <= 1'b1;
            end else begin
                mcu_reset_out_n_o <= 1'b1;
                // loads wait for the pin itself to read high, not only
                // for the drive to stop, and for a served watchdog
                if (wd_ok && line_hi) begin
                    reset_hold <= 1'b0; // [RL12]
                end
            end
        end
    end

    // output enables from state, faults and configuration
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_regulator_en <= 1'b0;
            aux_regulator_en  <= 1'b0;
            drivers_en        <= 1'b0;
            lin_tx_en         <= 1'b0;
            wdog_en           <= 1'b0;
            force_sleep       <= 1'b0;
        end else begin
            main_regulator_en <= (starting || running) && !th_off; // [RL5]
            aux_regulator_en  <= running && ctrl[`SRS_CT_AUX_EN]
                                 && !aux_block && !reset_hold
                                 && !th1; // [RL12] [RL15] [RL18]
            drivers_en <= running && !reset_hold && !th1 // [RL12] [RL15]
                && !(sup_low && ctrl[`SRS_CT_UV_DRV_OFF]) // [RL3]
                && !(sup_high && ctrl[`SRS_CT_OV_DRV_OFF]); // [RL4]
            lin_tx_en <= running && !sup_low; // [RL3]
            // in standby the watchdog follows the consumption monitor;
            // between the two thresholds it keeps its last state
            if (!running) begin
                wdog_en <= 1'b0;
            end else if (!ctrl[`SRS_CT_STANDBY]) begin
                wdog_en <= 1'b1;
            end else if (cur_high) begin
                wdog_en <= 1'b1; // [RL14]
            end else if (cur_low) begin
                wdog_en <= 1'b0; // [RL13]
            end
            force_sleep <= (state == ST_SLEEP); // [RL6] [RL7]
        end
    end

    // read data; live state, reset hold, watchdog, thermal-off and aux-block view on its own word
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= 32'h0;
        else if (psel && !penable && !pwrite) begin
            case (paddr)
                `SRS_ADDR_STATUS: prdata <= {24'h0, status};
                `SRS_ADDR_CLEAR:  prdata <= {24'h0, status};
                `SRS_ADDR_CTRL:   prdata <= {26'h0, ctrl};
                `SRS_ADDR_LIVE:   prdata <= {24'h0, state, reset_hold,
                                             wdog_en, th_off, aux_block};
                default:          prdata <= 32'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== tb/srs_chk_asserts.sv
// assertions on the supervisor ports
// assumes a bind into each srs_supervisor instance
`timescale 1ns/1ns
`default_nettype none
`include "srs_consts.vh"
module srs_chk #(
    parameter [26:0] SHORT_CYC = 27'h1,
    parameter [26:0] THERM_CYC = 27'h1
) (
    input wire       pclk,
    input wire       presetn,
    input wire       supply_above_por,
    input wire       supply_low,
    input wire [3:0] main_below_res,
    input wire       aux_above_fail,
    input wire       therm_level1,
    input wire       therm_level2,
    input wire       mcu_reset_out_n_o,
    input wire       mcu_reset_out_n_oe_n,
    input wire       main_regulator_en,
    input wire       aux_regulator_en,
    input wire       drivers_en,
    input wire       lin_tx_en
);
    localparam int RES_LIM = `SRS_MAIN_RES_CYC + 8;
    logic [10:0] low_n;
    logic [26:0] aux_n;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // run lengths: below every reset level, aux low while enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_n <= 11'h000;
            aux_n <= 27'h0;
        end else begin
            low_n <= (&main_below_res) ? low_n + {10'h0, ~&low_n}
                                       : 11'h000;
            aux_n <= (aux_above_fail | !aux_regulator_en) ? 27'h0
                                                          : aux_n + 27'h1;
        end
    end
    a_passive_off: assert property ((!supply_above_por)[*5] |->
        !(main_regulator_en | drivers_en | aux_regulator_en))
        else $error("output active without supply");
    a_uv_lin: assert property (supply_low[*5] |-> !lin_tx_en)
        else $error("lin send during supply low");
    a_t1_loads: assert property (therm_level1[*5] |->
        !(drivers_en | aux_regulator_en))
        else $error("loads on above first thermal level");
    a_t2_main: assert property ($rose(therm_level2) |->
        ##[1:5] !main_regulator_en)
        else $error("main regulator kept on at second level");
    a_res_filter: assert property (low_n >= RES_LIM |->
        !mcu_reset_out_n_o)
        else $error("reset not asserted after filter time");
    a_oe_match: assert property (mcu_reset_out_n_oe_n ==
        mcu_reset_out_n_o) else $error("reset enable mismatch");
    a_rst_loads: assert property ((!mcu_reset_out_n_o)[*3] |->
        !(drivers_en | aux_regulator_en))
        else $error("loads on during reset");
    a_aux_short: assert property (aux_n <= SHORT_CYC + 27'h8)
        else $error("shorted aux regulator left enabled");
endmodule
bind srs_supervisor srs_chk #(.SHORT_CYC(SHORT_CYC), .THERM_CYC(THERM_CYC))
    chk_u (.pclk, .presetn, .supply_above_por, .supply_low, .main_below_res,
    .aux_above_fail, .therm_level1, .therm_level2, .mcu_reset_out_n_o,
    .mcu_reset_out_n_oe_n, .main_regulator_en, .aux_regulator_en,
    .drivers_en, .lin_tx_en);
`default_nettype wire

// ===== tb/srs_mcu_model.sv
// microcontroller and regulator outputs seen by the supervisor
// assumes a pull-up on the reset line
`timescale 1ns/1ns
`default_nettype none
module srs_mcu_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic rst_o,
    input  wire logic rst_oe_n,
    input  wire logic main_en,
    input  wire logic aux_en,
    input  wire logic main_flt,
    input  wire logic aux_flt,
    output wire logic rst_line,
    output wire logic main_ok,
    output wire logic aux_ok,
    output wire logic served
);
    logic [7:0] cnt;
    // line pulled up, low only while the supervisor drives it
    assign rst_line = rst_oe_n ? 1'b1 : rst_o;
    // regulator outputs follow their enables unless shorted
    assign main_ok = main_en & ~main_flt;
    assign aux_ok = aux_en & ~aux_flt;
    // firmware serves the watchdog only while out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt <= 8'h00;
        else if (!rst_line)
            cnt <= 8'h00;
        else
            cnt <= cnt + 8'h01;
    end
    assign served = (cnt[5:2] == 4'hF);
endmodule
`default_nettype wire

// ===== tb/test_supply_regulator_supervisor.sv
// self-checking bench for the supply and regulator supervisor
// assumes the mcu model on the far side and a 100 MHz pclk
`timescale 1ns/1ns
`default_nettype none
`include "srs_consts.vh"
module test_supply_regulator_supervisor;
    localparam int SHORT = 1000;
    localparam logic [11:0] ST = `SRS_ADDR_STATUS;
    localparam logic [11:0] CL = `SRS_ADDR_CLEAR;
    localparam logic [11:0] CT = `SRS_ADDR_CTRL;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, s_por = 1'b0, s_low = 1'b0, s_high = 1'b0;
    logic        t1 = 1'b0, t2 = 1'b0, i_low = 1'b0, i_high = 1'b1;
    logic        m_flt = 1'b0, a_flt = 1'b0, rerr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdata;
    logic [3:0]  below = 4'h0;
    int          failures = 0, checked = 0;
    wire  [31:0] prdata;
    wire         pready, pslverr, rst_o, rst_oe_n, main_en, aux_en, drv_en;
    wire         lin_en, wd_en, sleep, rst_in, main_ok, aux_ok, srv;
    srs_supervisor #(.SHORT_CYC(SHORT[26:0]), .THERM_CYC(27'h64)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_above_por(s_por),
        .supply_low(s_low), .supply_high(s_high), .main_above_fail(main_ok),
        .main_below_res(below), .aux_above_fail(aux_ok),
        .therm_level1(t1), .therm_level2(t2), .load_current_low(i_low),
        .load_current_high(i_high), .wdog_served(srv), .cyclic_sense(1'b0),
        .mcu_reset_in(rst_in), .mcu_reset_out_n_o(rst_o),
        .mcu_reset_out_n_oe_n(rst_oe_n), .main_regulator_en(main_en),
        .aux_regulator_en(aux_en), .drivers_en(drv_en), .lin_tx_en(lin_en),
        .wdog_en(wd_en), .force_sleep(sleep));
    srs_mcu_model mcu_u (
        .pclk(pclk), .presetn(presetn), .rst_o(rst_o), .rst_oe_n(rst_oe_n),
        .main_en(main_en), .aux_en(aux_en), .main_flt(m_flt),
        .aux_flt(a_flt), .rst_line(rst_in), .main_ok(main_ok),
        .aux_ok(aux_ok), .served(srv));
    always #5 pclk = ~pclk;
    // compare one result, count and report
    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // apb transfer, request held until pready
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic loads_up();
        repeat (4000) if (drv_en !== 1'b1) @(posedge pclk);
        cmp("loads on", 2'h3, {drv_en, lin_en});
    endtask
    task automatic t_power();
        xfer(1'b1, CT, 32'h3C);
        cmp("passive", 3'h0, {main_en, drv_en, rst_in});
        s_por <= 1'b1;
        loads_up();
        xfer(1'b0, CT, 32'h0);
        cmp("ctrl default", `SRS_CT_RESET, rdata);
        xfer(1'b0, CL, 32'h0);
        cmp("cold flag", 1'b1, rdata[`SRS_ST_COLD]);
        xfer(1'b0, ST, 32'h0);
        cmp("cold cleared", 1'b0, rdata[`SRS_ST_COLD]);
        xfer(1'b0, 12'h010, 32'h0);
        cmp("unmapped", 33'h1_0000_0000 >> 32, {31'h0, rerr});
        $display("t_power done");
    endtask
    task automatic t_supply();
        s_low <= 1'b1;
        w(8);
        cmp("uv loads", 2'h0, {drv_en, lin_en});
        s_low <= 1'b0;
        s_high <= 1'b1;
        w(8);
        cmp("ov drivers", 1'b0, drv_en);
        s_high <= 1'b0;
        w(8);
        xfer(1'b0, CL, 32'h0);
        cmp("uv ov flags", 2'h3, rdata[2:1]);
        $display("t_supply done");
    endtask
    task automatic t_aux();
        loads_up();
        xfer(1'b1, CT, 32'h07);
        w(50);
        xfer(1'b0, CL, 32'h0);
        a_flt <= 1'b1;
        w(300);
        a_flt <= 1'b0;
        w(10);
        cmp("aux kept", 1'b1, aux_en);
        xfer(1'b0, CL, 32'h0);
        cmp("aux transient", 2'h1, rdata[5:4]);
        a_flt <= 1'b1;
        w(SHORT + 100);
        cmp("aux off", 1'b0, aux_en);
        a_flt <= 1'b0;
        xfer(1'b0, ST, 32'h0);
        cmp("aux short", 2'h3, rdata[5:4]);
        xfer(1'b0, CT, 32'h0);
        cmp("ctrl kept", 32'h07, rdata);
        cmp("aux held", 1'b0, aux_en);
        xfer(1'b0, CL, 32'h0);
        repeat (50) if (aux_en !== 1'b1) @(posedge pclk);
        cmp("aux again", 1'b1, aux_en);
        $display("t_aux done");
    endtask
    task automatic t_wdog();
        xfer(1'b1, CT, 32'h23);
        w(10);
        cmp("wdog busy", 1'b1, wd_en);
        i_high <= 1'b0;
        i_low <= 1'b1;
        w(10);
        cmp("wdog off", 1'b0, wd_en);
        i_high <= 1'b1;
        i_low <= 1'b0;
        w(10);
        cmp("wdog back", 1'b1, wd_en);
        xfer(1'b1, CT, 32'h03);
        $display("t_wdog done");
    endtask
    task automatic t_thresh();
        for (int s = 0; s < 4; s++) begin
            xfer(1'b1, CT, {27'h0, s[1:0], 3'h3});
            loads_up();
            below <= ~(4'h1 << s);
            w(1700);
            cmp("other level", 1'b1, rst_in);
            below <= 4'hF << s; // higher levels are crossed too
            w(1550);
            cmp("filtering", 1'b1, rst_in);
            w(100);
            cmp("reset", 2'h0, {rst_in, drv_en});
            below <= 4'h0;
            repeat (4000) if (rst_in !== 1'b1) @(posedge pclk);
            cmp("await wdog", 2'h2, {rst_in, drv_en});
        end
        $display("t_thresh done");
    endtask
    task automatic t_dip(input int n, input logic e);
        loads_up();
        xfer(1'b0, CL, 32'h0);
        m_flt <= 1'b1;
        below <= 4'hF;
        w(n);
        m_flt <= 1'b0;
        below <= 4'h0;
        w(20);
        xfer(1'b0, CL, 32'h0);
        cmp("main dip", e, rdata[`SRS_ST_MAIN_FAIL]);
        $display("t_dip done");
    endtask
    task automatic t_thermal();
        loads_up();
        t1 <= 1'b1;
        w(8);
        cmp("t1 loads", 2'h0, {drv_en, aux_en});
        t1 <= 1'b0;
        xfer(1'b0, CL, 32'h0);
        cmp("t1 flag", 1'b1, rdata[`SRS_ST_THERM1]);
        for (int k = 0; k < 4; k++) begin
            t2 <= 1'b1;
            w(80);
            cmp("t2 hold", 1'b0, main_en);
            t2 <= 1'b0;
            w(50);
            cmp("t2 back", k != 3, main_en);
        end
        cmp("sleep", 1'b1, sleep);
        s_por <= 1'b0;
        m_flt <= 1'b1;
        w(10);
        s_por <= 1'b1;
        w(SHORT - 100);
        cmp("no early sleep", 1'b0, sleep);
        repeat (300) if (sleep !== 1'b1) @(posedge pclk);
        cmp("start short", 1'b1, sleep);
        xfer(1'b0, ST, 32'h0);
        cmp("main fail", 1'b1, rdata[`SRS_ST_MAIN_FAIL]);
        $display("t_thermal done");
    endtask
    task automatic finish_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // main sequence after 20 reset cycles
    initial begin
        w(20);
        presetn <= 1'b1;
        w(10);
        t_power();
        t_supply();
        t_aux();
        t_wdog();
        t_thresh();
        t_dip(400, 1'b0);
        t_dip(600, 1'b1);
        t_thermal();
        finish_test();
    end
    // watchdog against a hang
    initial begin
        #500000;
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire
